// file: verilog/cmp_pkg.sv
// Purpose: shared constants and types for the dual comparator control block
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   offsets are byte addresses
package cmp_pkg;

  localparam logic [11:0] ctl0_offset   = 12'h000;
  localparam logic [11:0] ctl1_offset   = 12'h004;
  localparam logic [11:0] status_offset = 12'h008;
  localparam logic [11:0] vref_offset   = 12'h00C;
  localparam logic [11:0] clken_offset  = 12'h010;
  localparam logic [11:0] mask_offset   = 12'h014;

  localparam int irq_enable_bit = 1;
  localparam int neg_sel_lsb    = 4;
  localparam int edge_sel_lsb   = 8;
  localparam int filt_lsb       = 13;
  localparam int out_state_lsb  = 4;
  localparam int clk_gate_bit   = 7;
  localparam int ladder_lsb     = 0;

  localparam logic [31:0] ctl_write_mask  = 32'h0000_E33F;
  localparam logic [31:0] vref_write_mask = 32'h0000_000F;
  localparam logic [31:0] reg_reset_value = 32'h0000_0000;
  localparam logic [1:0]  resp_okay       = 2'b00;
  localparam logic [1:0]  resp_slverr     = 2'b10;

  localparam logic [1:0] edge_both    = 2'b00;
  localparam logic [1:0] edge_rising  = 2'b01;
  localparam logic [1:0] edge_falling = 2'b10;
  localparam logic [1:0] neg_pin      = 2'b00;
  localparam logic [1:0] neg_ladder   = 2'b01;
  localparam logic [1:0] neg_bandgap  = 2'b10;
  localparam logic [1:0] neg_dac      = 2'b11;

  localparam int          sync_stages  = 2;
  localparam logic [6:0]  filt_cnt_reset = 7'h00;

  typedef struct packed {
    logic [2:0] filter_count;
    logic [1:0] edge_select;
    logic [1:0] neg_select;
    logic       irq_enable;
  } cmp_cfg_type;

  typedef struct packed {
    logic [1:0] neg_select_0;
    logic [1:0] neg_select_1;
    logic [3:0] ladder_level;
    logic       ladder_enable;
  } analog_ctl_type;

  // number of equal samples a filter code asks for, 0 when off
  function automatic logic [6:0] filter_samples(input logic [2:0] code);
    filter_samples = (code == 3'd0) ? 7'd0 : 7'(7'd1 << (code - 3'd1));
  endfunction

endpackage

// file: verilog/cmp_sync.sv
// Purpose: two-stage synchroniser for one comparator output
// Assumes: input is fully asynchronous to aclk
// Notes:   first stage read only by second stage
`timescale 1ns/10ps
module cmp_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic async_in,
  output logic      sync_out
);

  logic [cmp_pkg::sync_stages-1:0] stage_q;
  logic [cmp_pkg::sync_stages-1:0] stage_d;

  always_comb begin
    stage_d = {stage_q[cmp_pkg::sync_stages-2:0], async_in};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_q <= '0;
    end else begin
      stage_q <= stage_d;
    end
  end

  assign sync_out = stage_q[cmp_pkg::sync_stages-1];

endmodule

// file: verilog/cmp_filter.sv
// Purpose: sample-count filter and edge detector for one comparator
// Assumes: input already synchronised to aclk
// Notes:   filter restarts its count whenever the raw level changes
`timescale 1ns/10ps
module cmp_filter (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic       raw_in,
  input  wire logic [2:0] filter_code,
  input  wire logic [1:0] edge_select,
  output logic            level_out,
  output logic            edge_hit
);

  logic       raw_prev_q;
  logic       raw_prev_d;
  logic [6:0] count_q;
  logic [6:0] count_d;
  logic       filt_q;
  logic       filt_d;
  logic       used_q;
  logic       used_d;
  logic [6:0] need;
  logic       used_now;

  always_comb begin
    need       = cmp_pkg::filter_samples(filter_code);
    raw_prev_d = raw_in;
    count_d    = count_q;
    filt_d     = filt_q;
    if (raw_in != raw_prev_q) begin
      count_d = 7'd1;
    end else if (count_q != 7'h7F) begin
      count_d = 7'(count_q + 7'd1);
    end
    // count_q holds the earlier equal samples, raw_in is the newest
    // tracks raw while off, so turning the filter on gives no false edge
    if (need <= 7'd1) begin
      filt_d = raw_in;
    end else if (raw_in == raw_prev_q && count_q >= 7'(need - 7'd1)) begin
      filt_d = raw_in;
    end
    used_now = (filter_code != 3'd0) ? filt_d : raw_in;
    used_d   = used_now;
    edge_hit = 1'b0;
    if (run) begin
      case (edge_select)
        cmp_pkg::edge_both:    edge_hit = used_now != used_q;
        cmp_pkg::edge_rising:  edge_hit = used_now & ~used_q;
        cmp_pkg::edge_falling: edge_hit = ~used_now & used_q;
        default:               edge_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_prev_q <= 1'b0;
      count_q    <= cmp_pkg::filt_cnt_reset;
      filt_q     <= 1'b0;
      used_q     <= 1'b0;
    end else begin
      raw_prev_q <= raw_prev_d;
      count_q    <= count_d;
      filt_q     <= filt_d;
      used_q     <= used_d;
    end
  end

  assign level_out = used_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_filter_hold;
    @(posedge aclk) disable iff (!aresetn)
      (filter_code == 3'd3 && $changed(filt_q)) |-> $past(raw_in, 1) == $past(raw_in, 4);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("filter moved too early");

  property p_filter_follow;
    @(posedge aclk) disable iff (!aresetn)
      (filter_code == 3'd3 && raw_in == $past(raw_in, 1) && raw_in == $past(raw_in, 2) &&
       raw_in == $past(raw_in, 3)) |=> filt_q == $past(raw_in);
  endproperty
  a_filter_follow: assert property (p_filter_follow) else $error("filter too slow");

  property p_rise_only;
    @(posedge aclk) disable iff (!aresetn)
      (edge_select == cmp_pkg::edge_rising && edge_hit) |-> used_d && !used_q;
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("rising select hit wrong edge");

  property p_raw_path;
    @(posedge aclk) disable iff (!aresetn)
      (filter_code == 3'd0) |=> level_out == $past(raw_in);
  endproperty
  a_raw_path: assert property (p_raw_path) else $error("unfiltered path lags");

endmodule

// file: verilog/cmp_control.sv
// Purpose: digital control of two analog comparators and the reference ladder
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes:   edge detection stops when the clock gate bit is low
// Operation
// - output is one when plus exceeds minus
// - both comparators share one interrupt
// - status bits 4 and 5 show levels
// - selected edge sets flag bit 0/1
// - edge select field at bits 9:8
// - 00 both, 01 rise, 10 fall
// - nonzero filter code uses filtered output
// - write one clears change flag
// - level must hold before filter follows
// - filter codes give 1 to 64 samples
// - ladder tap from reference bits 3:0
// - ladder off unless a select is 01
// - negative select: pin, ladder, bandgap, converter
// - logic runs only while gate bit set (only edge detection is gated here)
`timescale 1ns/10ps
module cmp_control (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    cmp0_analog_out,
  input  wire logic                    cmp1_analog_out,
  output cmp_pkg::analog_ctl_type      analog_ctl,
  output logic                         cmp_irq
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] ctl0_q, ctl0_d, ctl1_q, ctl1_d, vref_q, vref_d;
  logic [31:0] clken_q, clken_d, mask_q, mask_d;
  logic [1:0]  flag_q, flag_d;
  logic        aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  cmp_pkg::analog_ctl_type ana_q, ana_d;

  logic        sync0, sync1, lvl0, lvl1, hit0, hit1, run, do_write;
  cmp_pkg::cmp_cfg_type cfg0, cfg1;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb, input logic [31:0] keep);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    merge = res & keep;
  endfunction

  function automatic logic known(input logic [11:0] a);
    known = a == cmp_pkg::ctl0_offset || a == cmp_pkg::ctl1_offset ||
            a == cmp_pkg::status_offset || a == cmp_pkg::vref_offset ||
            a == cmp_pkg::clken_offset || a == cmp_pkg::mask_offset;
  endfunction

  function automatic cmp_pkg::cmp_cfg_type to_cfg(input logic [31:0] c);
    to_cfg.filter_count = c[cmp_pkg::filt_lsb +: 3];
    to_cfg.edge_select  = c[cmp_pkg::edge_sel_lsb +: 2];
    to_cfg.neg_select   = c[cmp_pkg::neg_sel_lsb +: 2];
    to_cfg.irq_enable   = c[cmp_pkg::irq_enable_bit];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // synchronise analog results
  cmp_sync u_sync0 (.aclk(aclk), .aresetn(aresetn), .async_in(cmp0_analog_out),
                    .sync_out(sync0));
  cmp_sync u_sync1 (.aclk(aclk), .aresetn(aresetn), .async_in(cmp1_analog_out),
                    .sync_out(sync1));

  assign cfg0 = to_cfg(ctl0_q);
  assign cfg1 = to_cfg(ctl1_q);
  assign run  = clken_q[cmp_pkg::clk_gate_bit];

  cmp_filter u_filt0 (.aclk(aclk), .aresetn(aresetn), .run(run), .raw_in(sync0),
                      .filter_code(cfg0.filter_count), .edge_select(cfg0.edge_select),
                      .level_out(lvl0), .edge_hit(hit0));
  cmp_filter u_filt1 (.aclk(aclk), .aresetn(aresetn), .run(run), .raw_in(sync1),
                      .filter_code(cfg1.filter_count), .edge_select(cfg1.edge_select),
                      .level_out(lvl1), .edge_hit(hit1));

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: address and data may come in either order
  always_comb begin
    aw_d     = aw_q;
    w_d      = w_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d     = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d     = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    do_write = aw_q && w_q && !bvalid_q;
    if (do_write) begin
      aw_d     = 1'b0;
      w_d      = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = known(awaddr_q) ? cmp_pkg::resp_okay : cmp_pkg::resp_slverr;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = known(s_axi_araddr) ? cmp_pkg::resp_okay : cmp_pkg::resp_slverr;
      case (s_axi_araddr)
        cmp_pkg::ctl0_offset:   rdata_d = ctl0_q;
        cmp_pkg::ctl1_offset:   rdata_d = ctl1_q;
        // levels at bits 4 and 5
        cmp_pkg::status_offset: rdata_d = {26'd0, lvl1, lvl0, 2'b00, flag_q};
        cmp_pkg::vref_offset:   rdata_d = vref_q;
        cmp_pkg::clken_offset:  rdata_d = clken_q;
        cmp_pkg::mask_offset:   rdata_d = mask_q;
        default:                rdata_d = cmp_pkg::reg_reset_value;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready  = !w_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // register file and sticky flags
  always_comb begin
    ctl0_d  = ctl0_q;
    ctl1_d  = ctl1_q;
    vref_d  = vref_q;
    clken_d = clken_q;
    mask_d  = mask_q;
    flag_d  = flag_q;
    if (do_write) begin
      case (awaddr_q)
        cmp_pkg::ctl0_offset:
          ctl0_d = merge(ctl0_q, wdata_q, wstrb_q, cmp_pkg::ctl_write_mask);
        cmp_pkg::ctl1_offset:
          ctl1_d = merge(ctl1_q, wdata_q, wstrb_q, cmp_pkg::ctl_write_mask);
        cmp_pkg::vref_offset:
          vref_d = merge(vref_q, wdata_q, wstrb_q, cmp_pkg::vref_write_mask);
        cmp_pkg::clken_offset:
          clken_d = merge(clken_q, wdata_q, wstrb_q, 32'h0000_0080);
        cmp_pkg::mask_offset:
          mask_d = merge(mask_q, wdata_q, wstrb_q, 32'h0000_0003);
        cmp_pkg::status_offset:
          if (wstrb_q[0]) begin
            flag_d = flag_q & ~wdata_q[1:0];
          end
        default: ;
      endcase
    end
    // selected edge sets flag
    // set wins over a clear in the same cycle
    flag_d = flag_d | {hit1, hit0};
  end

  always_comb begin
    ana_d.neg_select_0  = cfg0.neg_select;
    ana_d.neg_select_1  = cfg1.neg_select;
    ana_d.ladder_level  = vref_q[cmp_pkg::ladder_lsb +: 4];
    ana_d.ladder_enable = cfg0.neg_select == cmp_pkg::neg_ladder ||
                          cfg1.neg_select == cmp_pkg::neg_ladder;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl0_q   <= cmp_pkg::reg_reset_value;
      ctl1_q   <= cmp_pkg::reg_reset_value;
      vref_q   <= cmp_pkg::reg_reset_value;
      clken_q  <= cmp_pkg::reg_reset_value;
      mask_q   <= cmp_pkg::reg_reset_value;
      flag_q   <= 2'b00;
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= cmp_pkg::reg_reset_value;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= cmp_pkg::resp_okay;
      rvalid_q <= 1'b0;
      rresp_q  <= cmp_pkg::resp_okay;
      rdata_q  <= cmp_pkg::reg_reset_value;
      ana_q    <= '0;
    end else begin
      ctl0_q   <= ctl0_d;
      ctl1_q   <= ctl1_d;
      vref_q   <= vref_d;
      clken_q  <= clken_d;
      mask_q   <= mask_d;
      flag_q   <= flag_d;
      aw_q     <= aw_d;
      w_q      <= w_d;
      awaddr_q <= awaddr_d;
      wdata_q  <= wdata_d;
      wstrb_q  <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
      ana_q    <= ana_d;
    end
  end

  assign analog_ctl = ana_q;
  assign cmp_irq = |(flag_q & mask_q[1:0] &
                     {ctl1_q[cmp_pkg::irq_enable_bit], ctl0_q[cmp_pkg::irq_enable_bit]});

  ////////////////////////////////////////////////////////////////////////////
  property p_flag_set;
    @(posedge aclk) disable iff (!aresetn) hit0 |=> flag_q[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("edge did not set flag");

  property p_flag_clear;
    @(posedge aclk) disable iff (!aresetn)
      (do_write && awaddr_q == cmp_pkg::status_offset && wstrb_q[0] && wdata_q[1] && !hit1)
        |=> !flag_q[1];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_flag_keep;
    @(posedge aclk) disable iff (!aresetn) (flag_q[0] && !(do_write && wdata_q[0])) |=> flag_q[0];
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag lost");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
      (flag_q[1] && mask_q[1] && ctl1_q[cmp_pkg::irq_enable_bit]) |-> cmp_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_ladder;
    @(posedge aclk) disable iff (!aresetn)
      (cfg0.neg_select != cmp_pkg::neg_ladder && cfg1.neg_select != cmp_pkg::neg_ladder)
        |=> !analog_ctl.ladder_enable;
  endproperty
  a_ladder: assert property (p_ladder) else $error("ladder left on");

  property p_tap;
    @(posedge aclk) disable iff (!aresetn) 1'b1 |=> analog_ctl.ladder_level == $past(vref_q[3:0]);
  endproperty
  a_tap: assert property (p_tap) else $error("ladder tap wrong");

  property p_gate;
    @(posedge aclk) disable iff (!aresetn) !run |=> flag_q == $past(flag_q) || $past(do_write);
  endproperty
  a_gate: assert property (p_gate) else $error("flag moved while gated");

  property p_level;
    @(posedge aclk) disable iff (!aresetn)
      (cfg0.filter_count == 3'd0) ##1 (cfg0.filter_count == 3'd0)[*3] |-> lvl0 == $past(cmp0_analog_out, 3);
  endproperty
  a_level: assert property (p_level) else $error("level not tracking input");

endmodule

// file: tb/cmp_analog_model.sv
// Purpose: behavioural comparator pair with reference ladder
// Assumes: voltages in millivolts, ladder step and band-gap are plain defaults
// Notes:   ladder gives 0 mV while switched off
`timescale 1ns/10ps
module cmp_analog_model #(
  parameter int ladder_step_mv = 200,
  parameter int bandgap_mv     = 1200
) (
  input  wire logic [15:0]             pos0_mv,
  input  wire logic [15:0]             pos1_mv,
  input  wire logic [15:0]             pin_mv,
  input  wire logic [15:0]             dac_mv,
  input  wire cmp_pkg::analog_ctl_type analog_ctl,
  output logic                         cmp0_out,
  output logic                         cmp1_out
);
  logic [15:0] ladder_mv;
  logic [15:0] neg0_mv;
  logic [15:0] neg1_mv;

  function automatic logic [15:0] pick(input logic [1:0] sel, input logic [15:0] lad);
    case (sel)
      cmp_pkg::neg_pin:    pick = pin_mv;
      cmp_pkg::neg_ladder: pick = lad;
      cmp_pkg::neg_dac:    pick = dac_mv;
      default:             pick = 16'(bandgap_mv);
    endcase
  endfunction

  assign ladder_mv = analog_ctl.ladder_enable ?
                     16'(int'(analog_ctl.ladder_level) * ladder_step_mv) : 16'h0000;
  // negative input routing
  // the function also reads the pin and converter levels
  always_comb begin
    neg0_mv = pick(analog_ctl.neg_select_0, ladder_mv);
    neg1_mv = pick(analog_ctl.neg_select_1, ladder_mv);
  end
  assign cmp0_out = pos0_mv > neg0_mv;
  assign cmp1_out = pos1_mv > neg1_mv;
endmodule

// file: tb/dual_comparator_control_tb_top.sv
// Purpose: self-checking bench for the dual comparator control block
// Assumes: flags settle within 12 cycles with the filter off
// Notes:   bus tasks sample handshakes at the falling edge before acting
`timescale 1ns/10ps
module dual_comparator_control_tb_top;
  logic                    aclk    = 1'b0;
  logic                    aresetn = 1'b0;
  logic [11:0]             awaddr  = 12'h000;
  logic [11:0]             araddr  = 12'h000;
  logic [31:0]             wdata   = 32'h0000_0000;
  logic [3:0]              wstrb   = 4'h0;
  logic                    awvalid = 1'b0;
  logic                    wvalid  = 1'b0;
  logic                    bready  = 1'b0;
  logic                    arvalid = 1'b0;
  logic                    rready  = 1'b0;
  logic [15:0]             pos0    = 16'h0064;
  logic [15:0]             pos1    = 16'h0064;
  logic                    awready, wready, bvalid, arready, rvalid, cmp_irq, cmp0_out, cmp1_out;
  logic [1:0]              bresp, rresp, resp;
  logic [31:0]             rdata, st;
  cmp_pkg::analog_ctl_type analog_ctl;
  int                      n_fail    = 0;
  int                      compares  = 0;
  int unsigned             seed, g, n;
  logic [11:0]             regs [6]  = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014};

  always #20 aclk = ~aclk;

  cmp_control uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cmp0_analog_out(cmp0_out), .cmp1_analog_out(cmp1_out), .analog_ctl(analog_ctl),
    .cmp_irq(cmp_irq));

  cmp_analog_model partner (.pos0_mv(pos0), .pos1_mv(pos1), .pin_mv(16'h01F4),
    .dac_mv(16'h0000), .analog_ctl(analog_ctl), .cmp0_out(cmp0_out), .cmp1_out(cmp1_out));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_hit, w_hit, b_hit;
    b_hit = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int i = 0; i < 100 && !b_hit; i++) begin
      @(negedge aclk);
      aw_hit = awvalid && awready;
      w_hit  = wvalid && wready;
      b_hit  = bvalid && bready;
      resp   = bresp;
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (b_hit) bready <= 1'b0;
    end
    if (!b_hit) chk(32'h0000_0000, 32'h0000_0001, "write answer");
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic ar_hit, r_hit;
    r_hit = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int i = 0; i < 100 && !r_hit; i++) begin
      @(negedge aclk);
      ar_hit = arvalid && arready;
      r_hit  = rvalid && rready;
      d      = rdata;
      resp   = rresp;
      @(posedge aclk);
      if (ar_hit) arvalid <= 1'b0;
      if (r_hit) rready <= 1'b0;
    end
    if (!r_hit) chk(32'h0000_0000, 32'h0000_0001, "read answer");
  endtask

  // one comparator output driven high or low through the model
  task automatic lvl(input int c, input logic v);
    @(posedge aclk);
    if (c == 0) pos0 <= v ? 16'h0384 : 16'h0064;
    else pos1 <= v ? 16'h0384 : 16'h0064;
  endtask

  task automatic settle(input int unsigned k);
    repeat (k) @(posedge aclk);
  endtask

  function automatic logic fires(input logic [1:0] e, input logic rise);
    return (e == cmp_pkg::edge_both) || (e == cmp_pkg::edge_rising && rise) ||
           (e == cmp_pkg::edge_falling && !rise);
  endfunction

  function automatic logic [31:0] stat(input int c, input logic l, input logic f);
    stat = 32'h0000_0000;
    stat[4 + c] = l;
    stat[c] = f;
  endfunction

  task automatic stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge aclk);
    n_fail++;
    stop_test();
  end

  initial begin
    seed = $urandom(32'h0000_0566);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i]) begin
      rd(regs[i], st);
      chk(st, cmp_pkg::reg_reset_value, "reset value");
      chk(32'(resp), 32'(cmp_pkg::resp_okay), "read okay");
    end
    rd(12'h018, st);
    chk({resp, st}, {cmp_pkg::resp_slverr, 32'h0000_0000}, "unmapped read");
    wr(12'h018, 32'h0000_0080);
    chk(32'(resp), 32'(cmp_pkg::resp_slverr), "unmapped write");
    wr(cmp_pkg::ctl0_offset, 32'hFFFF_FFFF);
    chk(32'(resp), 32'(cmp_pkg::resp_okay), "write okay");
    rd(cmp_pkg::ctl0_offset, st);
    chk(st, cmp_pkg::ctl_write_mask, "ctl access");
    wr(cmp_pkg::vref_offset, 32'hFFFF_FFFF);
    rd(cmp_pkg::vref_offset, st);
    chk(st, cmp_pkg::vref_write_mask, "vref access");
    wr(cmp_pkg::ctl0_offset, 32'h0000_0000);
    wr(cmp_pkg::clken_offset, 32'h0000_0080);
    wr(cmp_pkg::mask_offset, 32'h0000_0003);
    $display("test registers done");
    for (int c = 0; c < 2; c++) begin
      for (int e = 0; e < 4; e++) begin
        wr(c ? cmp_pkg::ctl1_offset : cmp_pkg::ctl0_offset, 32'(e << 8) | 32'h0000_0002);
        wr(cmp_pkg::status_offset, 32'h0000_0003);
        lvl(c, 1'b1);
        settle(12);
        rd(cmp_pkg::status_offset, st);
        chk(st, stat(c, 1'b1, fires(2'(e), 1'b1)), "rise flag");
        chk(32'(cmp_irq), 32'(fires(2'(e), 1'b1)), "rise irq");
        wr(cmp_pkg::status_offset, 32'h0000_0000);
        rd(cmp_pkg::status_offset, st);
        chk(st, stat(c, 1'b1, fires(2'(e), 1'b1)), "zero write");
        wr(cmp_pkg::status_offset, 32'(1 << c));
        lvl(c, 1'b0);
        settle(12);
        rd(cmp_pkg::status_offset, st);
        chk(st, stat(c, 1'b0, fires(2'(e), 1'b0)), "fall flag");
        wr(cmp_pkg::status_offset, 32'(1 << c));
        rd(cmp_pkg::status_offset, st);
        chk(st, 32'h0000_0000, "one clears");
      end
    end
    $display("test edges done");
    for (int f = 3; f < 8; f += 2) begin
      n = 1 << (f - 1);
      g = 1 + $urandom % (n - 2);
      wr(cmp_pkg::ctl0_offset, 32'(f << 13));
      wr(cmp_pkg::status_offset, 32'h0000_0003);
      lvl(0, 1'b1);
      settle(g);
      lvl(0, 1'b0);
      settle(n + 12);
      rd(cmp_pkg::status_offset, st);
      chk(st, 32'h0000_0000, "glitch ignored");
      lvl(0, 1'b1);
      settle(n + 12);
      rd(cmp_pkg::status_offset, st);
      chk(st, stat(0, 1'b1, 1'b1), "filtered edge");
      lvl(0, 1'b0);
      settle(n + 12);
    end
    $display("test filter done");
    wr(cmp_pkg::ctl0_offset, 32'h0000_0000);
    wr(cmp_pkg::clken_offset, 32'h0000_0000);
    wr(cmp_pkg::status_offset, 32'h0000_0003);
    lvl(0, 1'b1);
    settle(12);
    rd(cmp_pkg::status_offset, st);
    chk(st, stat(0, 1'b1, 1'b0), "gated flag");
    wr(cmp_pkg::clken_offset, 32'h0000_0080);
    lvl(0, 1'b0);
    wr(cmp_pkg::ctl1_offset, 32'h0000_0002);
    wr(cmp_pkg::mask_offset, 32'h0000_0000);
    lvl(1, 1'b1);
    settle(12);
    chk(32'(cmp_irq), 32'h0000_0000, "masked irq");
    wr(cmp_pkg::mask_offset, 32'h0000_0002);
    settle(2);
    chk(32'(cmp_irq), 32'h0000_0001, "unmasked irq");
    wr(cmp_pkg::status_offset, 32'h0000_0003);
    settle(2);
    chk(32'(cmp_irq), 32'h0000_0000, "irq cleared");
    $display("test gate and irq done");
    for (int i = 0; i < 6; i++) begin
      st = $urandom;
      wr(cmp_pkg::ctl0_offset, {26'h000_0000, st[5:4], 4'h0});
      wr(cmp_pkg::ctl1_offset, {26'h000_0000, st[7:6], 4'h0});
      wr(cmp_pkg::vref_offset, {28'h000_0000, st[3:0]});
      settle(2);
      chk(32'(analog_ctl), 32'({st[5:4], st[7:6], st[3:0],
          st[5:4] == cmp_pkg::neg_ladder || st[7:6] == cmp_pkg::neg_ladder}), "ladder");
    end
    wr(cmp_pkg::ctl0_offset, 32'h0000_0010);
    wr(cmp_pkg::vref_offset, 32'h0000_0008);
    pos0 <= 16'h07D0;
    settle(12);
    rd(cmp_pkg::status_offset, st);
    chk(st & 32'h0000_0010, 32'h0000_0010, "above ladder");
    pos0 <= 16'h03E8;
    settle(12);
    rd(cmp_pkg::status_offset, st);
    chk(st & 32'h0000_0010, 32'h0000_0000, "below ladder");
    $display("test ladder done");
    stop_test();
  end
endmodule
